// ===== src/sar_ctrl.sv
/*
 readout and reset control of a 16-bit successive-approximation converter.
 assumes host pins are asynchronous; the analog core supplies a two's
 complement code on core_result, latched in the done state at end of conversion.
*/
`timescale 1ns/1ps
module sar_ctrl (
   // clock and core reset
   input  wire logic                         clock,
   input  wire logic                         rst_n,
   // host pins
   input  wire logic                         reset_pin_n,
   input  wire logic                         chip_select_n,
   input  wire logic                         read_n,
   input  wire logic                         conversion_start_n,
   input  wire logic                         byte_select,
   // analog core
   input  wire logic [sar_pkg::DATA_W-1:0]   core_result,
   output logic                              core_sample,
   output logic                              core_convert,
   // host outputs
   output logic                              busy,
   output logic [7:0]                        upper_bus_lanes,
   output logic [7:0]                        lower_bus_lanes,
   output logic                              bus_oe
);
   import sar_pkg::*;

   // synchronised pins and their edges
   logic                rst_s;
   logic                cs_s;
   logic                rd_s;
   logic                cv_s;
   logic                byte_s;
   logic                cs_d_reg;
   logic                cv_d_reg;
   logic                cs_fall;
   logic                cv_fall;
   logic                start_ok;

   // reset sources
   logic                edge_rst;
   logic                hold_rst;
   logic [2:0]          por_cnt_reg;
   logic                por_done_reg;

   // sequencer
   logic [CNT_W-1:0]    cnt_reg;
   logic [CNT_W-1:0]    cnt_next;
   logic                first_reg;
   logic                busy_fell_reg;
   logic                sample_ok;
   sar_state_t          state_reg;
   sar_state_t          state_next;

   // output latches
   logic [DATA_W-1:0]   result_reg;

   // upper lanes for either byte select setting
   function automatic logic [7:0] upper_lane(
      input logic              sel,
      input logic [DATA_W-1:0] word
   );
      upper_lane = sel ? word[7:0] : word[15:8];
   endfunction : upper_lane

   // lower lanes: all ones while the low byte sits on the upper lanes
   function automatic logic [7:0] lower_lane(
      input logic              sel,
      input logic [DATA_W-1:0] word
   );
      lower_lane = sel ? LANE_ONES : word[7:0];
   endfunction : lower_lane

   // dedicated reset pin, seen as asserted until synchronised high
   sar_sync #(
      .INIT  (1'b0)
   ) u_rst (
      .clock (clock),
      .rst_n (rst_n),
      .pin   (reset_pin_n),
      .level (rst_s)
   );

   // chip select, idle high
   sar_sync #(
      .INIT  (1'b1)
   ) u_cs (
      .clock (clock),
      .rst_n (rst_n),
      .pin   (chip_select_n),
      .level (cs_s)
   );

   // read strobe, idle high
   sar_sync #(
      .INIT  (1'b1)
   ) u_rd (
      .clock (clock),
      .rst_n (rst_n),
      .pin   (read_n),
      .level (rd_s)
   );

   // conversion start, idle high
   sar_sync #(
      .INIT  (1'b1)
   ) u_cv (
      .clock (clock),
      .rst_n (rst_n),
      .pin   (conversion_start_n),
      .level (cv_s)
   );

   // byte select
   sar_sync #(
      .INIT  (1'b0)
   ) u_byte (
      .clock (clock),
      .rst_n (rst_n),
      .pin   (byte_select),
      .level (byte_s)
   );

   // previous select level; idle high, so no false edge after reset
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cs_d_reg <= 1'b1;
      end else begin
         cs_d_reg <= cs_s;
      end
   end

   // previous start level; idle high, so no false edge after reset
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cv_d_reg <= 1'b1;
      end else begin
         cv_d_reg <= cv_s;
      end
   end

   assign cs_fall   = cs_d_reg & ~cs_s;
   assign cv_fall   = cv_d_reg & ~cv_s;
   assign start_ok  = cv_fall & ~cs_s;
   // self-clearing reset: one pulse, nothing for the host to release
   assign edge_rst  = (state_reg == SAR_ST_CONV) & (start_ok | cs_fall);
   // reset acts whatever chip select does; the pin arrives two edges late,
   // well inside the abort limit
   assign hold_rst  = ~rst_s | ~por_done_reg | edge_rst;
   // first sampling uses the fixed delay, later ones wait for busy and select
   assign sample_ok = first_reg ? (cnt_reg == '0) : (busy_fell_reg & ~cs_s);

   // internal power-on reset count
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         por_cnt_reg <= 3'h0;
      end else if (!por_done_reg) begin
         por_cnt_reg <= por_cnt_reg + 3'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         por_done_reg <= 1'b0;
      end else if (por_cnt_reg == 3'(POR_CYC - 1)) begin
         por_done_reg <= 1'b1;
      end
   end

   // sequencer
   always_comb begin
      state_next = state_reg;
      cnt_next   = (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
      case (state_reg)
         SAR_ST_RESET: begin
            // leaves reset one cycle after release, then waits to sample
            state_next = SAR_ST_WAIT;
            cnt_next   = sar_cyc(SAMPLE_DLY_CYC);
         end
         SAR_ST_WAIT: begin
            if (sample_ok) begin
               state_next = SAR_ST_SAMPLE;
            end
         end
         SAR_ST_SAMPLE: begin
            if (start_ok) begin
               state_next = SAR_ST_CONV;
               cnt_next   = sar_cyc(CONV_CYC);
            end
         end
         SAR_ST_CONV: begin
            if (cnt_reg == '0) begin
               state_next = SAR_ST_DONE;
            end
         end
         SAR_ST_DONE: begin
            state_next = SAR_ST_WAIT;
         end
         default: begin
            state_next = SAR_ST_RESET;
            cnt_next   = '0;
         end
      endcase
   end

   // any reset source forces the reset state, aborting in one cycle
   always_ff @(posedge clock) begin
      if (!rst_n || hold_rst) begin
         state_reg <= SAR_ST_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n || hold_rst) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   // first sampling after a reset uses the fixed delay
   always_ff @(posedge clock) begin
      if (!rst_n || hold_rst) begin
         first_reg <= 1'b1;
      end else if (state_reg == SAR_ST_SAMPLE) begin
         first_reg <= 1'b0;
      end
   end

   // remembers that busy has fallen, so sampling waits for select
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         busy_fell_reg <= 1'b0;
      end else if (state_reg != SAR_ST_WAIT) begin
         busy_fell_reg <= (state_reg == SAR_ST_DONE);
      end
   end

   // busy stands for the whole conversion
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         busy <= 1'b0;
      end else begin
         busy <= (state_next == SAR_ST_CONV) && !hold_rst;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         core_sample <= 1'b0;
      end else begin
         core_sample <= (state_next == SAR_ST_SAMPLE) && !hold_rst;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         core_convert <= 1'b0;
      end else begin
         core_convert <= (state_next == SAR_ST_CONV) && !hold_rst;
      end
   end

   // output latches
   always_ff @(posedge clock) begin
      if (!rst_n || hold_rst) begin
         result_reg <= RESULT_RST;
      end else if (state_reg == SAR_ST_DONE) begin
         result_reg <= core_result;
      end
   end

   // bus enable follows select and read
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         bus_oe <= 1'b0;
      end else begin
         bus_oe <= ~cs_s & ~rd_s;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         upper_bus_lanes <= 8'h00;
      end else begin
         upper_bus_lanes <= upper_lane(byte_s, result_reg);
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         lower_bus_lanes <= 8'h00;
      end else begin
         lower_bus_lanes <= lower_lane(byte_s, result_reg);
      end
   end
endmodule : sar_ctrl

// ===== src/sar_pkg.sv
/*
 package of constants for the converter readout and reset control.
 assumes a 125 MHz core clock; times are in nanoseconds.
*/
// Operation
// - byte select swaps lanes, low lanes ones
// - dedicated reset low, asynchronous, ignores select
// - abort running conversion within 50 ns
// - reset clears output latches to zero
// - normal operation within 20 ns after release
// - first sampling starts 20 ns after release; code starts it on the sixth clock edge after the pin rises, about 40 to 48 ns
// - sampling starts at later of busy/select fall
// - busy high for whole conversion
// - start edge during conversion, selected, resets
// - select falling edge during conversion resets
// - edge-fired reset clears itself
// - internal power-on reset, no pulse needed
// - start low with select low raises busy
// - bus driven only when select and read low
// - result in two's complement
package sar_pkg;
   localparam int          CLK_PERIOD_NS   = 8;
   localparam int          RST_MIN_NS      = 25;
   localparam int          ABORT_MAX_NS    = 50;
   localparam int          RECOVER_MAX_NS  = 20;
   localparam int          SAMPLE_DLY_NS   = 20;
   localparam int          CONV_TIME_NS    = 650;
   localparam int          ACQ_TIME_NS     = 150;
   localparam int          RST_MIN_CYC     = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          ABORT_MAX_CYC   = ABORT_MAX_NS / CLK_PERIOD_NS;
   localparam int          RECOVER_CYC     = RECOVER_MAX_NS / CLK_PERIOD_NS;
   localparam int          SAMPLE_DLY_CYC  = SAMPLE_DLY_NS / CLK_PERIOD_NS;
   localparam int          CONV_CYC        = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam int          ACQ_CYC         = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          DATA_W          = 16;
   localparam int          CNT_W           = 8;
   localparam logic [15:0] RESULT_RST      = 16'h0000;
   localparam logic [7:0]  LANE_ONES       = 8'hFF;
   localparam int          POR_CYC         = 4;

   typedef enum logic [4:0] {
      SAR_ST_RESET  = 5'b00001,
      SAR_ST_WAIT   = 5'b00010,
      SAR_ST_SAMPLE = 5'b00100,
      SAR_ST_CONV   = 5'b01000,
      SAR_ST_DONE   = 5'b10000
   } sar_state_t;

   function automatic logic [CNT_W-1:0] sar_cyc(input int n);
      sar_cyc = CNT_W'(n);
   endfunction : sar_cyc
endpackage : sar_pkg

// ===== src/sar_sync.sv
/*
 two flip-flop synchroniser for one pin, reset value chosen by parameter.
 assumes the pin is asynchronous to clock.
*/
`timescale 1ns/1ps
module sar_sync #(
   parameter logic INIT = 1'b1
) (
   // clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   // pin and synchronised level
   input  wire logic pin,
   output logic      level
);
   logic meta_reg;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         meta_reg <= INIT;
         level    <= INIT;
      end else begin
         meta_reg <= pin;
         level    <= meta_reg;
      end
   end
endmodule : sar_sync

// ===== verification/sar_core_model.sv
/*
 analog core stand-in: holds the code given by the bench from the end of sampling.
 assumes the bench sets code before the conversion starts.
*/
`timescale 1ns/1ps
module sar_core_model (
   // clock and core strobes
   input  wire logic        clock,
   input  wire logic        core_sample,
   // code to convert and held result
   input  wire logic [15:0] code,
   output logic      [15:0] core_result
);
   logic sample_reg = 1'b0;
   initial core_result = 16'hA5A5;
   // hold mode begins when sampling ends
   always @(posedge clock) begin
      sample_reg <= core_sample;
      if (sample_reg && !core_sample) core_result <= code;
   end
endmodule : sar_core_model

// ===== verification/sar_ctrl_props.sv
/*
 concurrent checks on the converter control ports.
 assumes one clock domain and the synchronous core reset.
*/
`timescale 1ns/1ps
module sar_ctrl_props (
   // clock, reset and host pins
   input wire logic        clock, rst_n, reset_pin_n, chip_select_n, read_n, conversion_start_n, byte_select,
   // core side
   input wire logic [15:0] core_result,
   input wire logic        core_sample, core_convert,
   // host outputs
   input wire logic        busy, bus_oe,
   input wire logic [7:0]  upper_bus_lanes, lower_bus_lanes
);
   localparam int BUSY_MAX = sar_pkg::CONV_CYC + 1;
   logic [3:0] up_cnt;
   logic [7:0] busy_cnt;
   logic       armed;
   always_ff @(posedge clock) up_cnt <= !rst_n ? 4'h0 : (up_cnt == 4'hF ? up_cnt : up_cnt + 4'h1);
   always_ff @(posedge clock) busy_cnt <= (!rst_n || !busy) ? 8'h00 : busy_cnt + 8'h01;
   assign armed = (up_cnt == 4'hF);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   oe_on_a: assert property ((armed && !chip_select_n && !read_n)[*5] |=> bus_oe) else $error("bus idle");
   oe_off_a: assert property ((armed && (chip_select_n || read_n))[*5] |=> !bus_oe) else $error("bus driven");
   lane_ones_a: assert property ((armed && byte_select)[*5] |=> lower_bus_lanes == 8'hFF) else $error("low lanes");
   clear_zero_a: assert property ((!reset_pin_n && !byte_select)[*5] |=> {upper_bus_lanes, lower_bus_lanes} == 16'h0000)
      else $error("result not cleared");
   pin_abort_a: assert property ($fell(reset_pin_n) |-> ##[1:6] !busy) else $error("busy in reset");
   busy_len_a: assert property (busy_cnt <= BUSY_MAX) else $error("busy too long");
   busy_hold_a: assert property (armed && reset_pin_n && $rose(busy) |-> busy[*8]) else $error("busy short");
   start_busy_a: assert property (armed && core_sample && !chip_select_n && $fell(conversion_start_n) |-> ##[2:6] busy)
      else $error("no busy");
   cs_abort_a: assert property (armed && busy && $fell(chip_select_n) |-> ##[1:7] !busy) else $error("select abort");
   st_abort_a: assert property (armed && busy && !chip_select_n && $fell(conversion_start_n) |-> ##[1:7] !busy)
      else $error("start abort");
   recover_a: assert property (armed && $rose(reset_pin_n) |-> ##[1:8] core_sample) else $error("no sampling");
   cover property ($fell(busy));
   cover property (bus_oe && byte_select);
   cover property ($rose(reset_pin_n));
endmodule : sar_ctrl_props
bind sar_ctrl sar_ctrl_props u_props (.clock(clock), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
   .chip_select_n(chip_select_n), .read_n(read_n), .conversion_start_n(conversion_start_n),
   .byte_select(byte_select), .core_result(core_result), .core_sample(core_sample), .core_convert(core_convert),
   .busy(busy), .bus_oe(bus_oe), .upper_bus_lanes(upper_bus_lanes), .lower_bus_lanes(lower_bus_lanes));

// ===== verification/sar_ctrl_tb.sv
/*
 self-checking bench for the converter control: conversions, reads, resets.
 assumes the core model answers and the bench resolves the bus wire.
*/
`timescale 1ns/1ps
module sar_ctrl_tb;
   import sar_pkg::*;
   logic clock = 0, rst_n = 0, reset_pin_n = 1, chip_select_n = 1, read_n = 1, conversion_start_n = 1;
   logic byte_select = 0, core_sample, core_convert, busy, bus_oe;
   logic [15:0] core_code = 16'h0000, core_result;
   logic [7:0]  upper_bus_lanes, lower_bus_lanes;
   int          err_total = 0, total_checks = 0;
   wire  [15:0] bus = bus_oe ? {upper_bus_lanes, lower_bus_lanes} : 16'hZZZZ;
   always #4 clock = ~clock;
   sar_core_model core (.clock(clock), .core_sample(core_sample), .code(core_code), .core_result(core_result));
   sar_ctrl dut (.clock(clock), .rst_n(rst_n), .reset_pin_n(reset_pin_n), .chip_select_n(chip_select_n),
      .read_n(read_n), .conversion_start_n(conversion_start_n), .byte_select(byte_select), .core_result(core_result),
      .core_sample(core_sample), .core_convert(core_convert), .busy(busy), .upper_bus_lanes(upper_bus_lanes),
      .lower_bus_lanes(lower_bus_lanes), .bus_oe(bus_oe));
   task test_done;
      if (err_total == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : test_done
   task chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : cyc
   // start a conversion and hold start until busy answers
   task start_conv;
      int n;
      chip_select_n = 0;
      cyc(8);
      conversion_start_n = 0;
      for (n = 0; n < 10 && busy !== 1'b1; n++) cyc(1);
      if (busy !== 1'b1) begin
         err_total++;
         test_done();
      end
      conversion_start_n = 1;
   endtask : start_conv
   // waits for busy to fall, returns the cycles it stood
   task wait_idle(output int m);
      for (m = 0; m < 200 && busy === 1'b1; m++) cyc(1);
      if (busy === 1'b1) begin
         err_total++;
         test_done();
      end
   endtask : wait_idle
   // throwaway conversions after power-on
   task t_warm;
      int k, w;
      for (k = 0; k < 3; k++) begin
         start_conv();
         wait_idle(w);
      end
   endtask : t_warm
   task t_conv(input logic [15:0] code);
      int m;
      core_code = code;
      start_conv();
      chk(16'(core_convert), 16'h0001);
      wait_idle(m);
      chk(16'(m), 16'(CONV_CYC + 1));
      cyc(4);
      chk(16'(core_sample), 16'h0001);
      byte_select = 0;
      read_n = 0;
      cyc(6);
      chk(bus, code);
      byte_select = 1;
      cyc(6);
      chk(bus, {code[7:0], 8'hFF});
      read_n = 1;
      cyc(6);
      chk(bus, 16'hZZZZ);
   endtask : t_conv
   task t_pin;
      core_code = 16'h5A3C;
      byte_select = 0;
      start_conv();
      chip_select_n = 1;
      cyc(10);
      reset_pin_n = 0;
      cyc(6);
      chk(16'(busy), 16'h0000);
      reset_pin_n = 1;
      cyc(6);
      chk(16'(core_sample), 16'h0001);
      chip_select_n = 0;
      read_n = 0;
      cyc(6);
      chk(bus, 16'h0000);
      read_n = 1;
   endtask : t_pin
   task t_abort(input logic by_cs);
      t_conv(16'h7E81);
      start_conv();
      cyc(20);
      chk(16'(busy), 16'h0001);
      if (by_cs) begin
         chip_select_n = 1;
         cyc(4);
         chip_select_n = 0;
      end else conversion_start_n = 0;
      cyc(8);
      chk(16'(busy), 16'h0000);
      conversion_start_n = 1;
      read_n = 0;
      byte_select = 0;
      cyc(6);
      chk(bus, 16'h0000);
      chk(16'(core_sample), 16'h0001);
      read_n = 1;
   endtask : t_abort
   initial begin
      cyc(10);
      rst_n = 1;
      cyc(30);
      chk(16'(core_sample), 16'h0001);
      t_warm();
      t_conv(16'h7FFF);
      t_conv(16'h8000);
      t_conv(16'h0000);
      t_conv(16'h12C4);
      t_pin();
      t_abort(1'b1);
      t_abort(1'b0);
      t_conv(16'hFFFF);
      test_done();
   end
endmodule : sar_ctrl_tb
